// ==== hw/exec_unit_pkg.sv ====
package exec_unit_pkg;

  // bus map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_ACCUM = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_PC = 8'h18;
  localparam logic [7:0] ADDR_STACK_TOP = 8'h1C;

  // ctrl word: opcode [4:0], bit select [10:8], go [16]
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BIT_LSB = 8;
  localparam int CTRL_GO_BIT = 16;

  // flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_GIE = 4;

  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_INTERRUPT_RETURN,
    OP_ROTATE_LEFT_MEM,
    OP_ROTATE_LEFT_TO_ACCUM,
    OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_ROTATE_LEFT_CARRY_TO_ACCUM,
    OP_ROTATE_RIGHT_MEM,
    OP_ROTATE_RIGHT_TO_ACCUM,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_ROTATE_RIGHT_CARRY_TO_ACCUM,
    OP_SUBTRACT_BORROW_TO_ACCUM,
    OP_SUBTRACT_BORROW_TO_MEM,
    OP_DEC_SKIP_ZERO,
    OP_DEC_TO_ACCUM_SKIP_ZERO,
    OP_INC_SKIP_ZERO,
    OP_INC_TO_ACCUM_SKIP_ZERO,
    OP_SET_BYTE,
    OP_SET_BIT,
    OP_BIT_TEST_SKIP_NONZERO
  } op_t;

  typedef struct packed {
    logic c;
    logic ac;
    logic z;
    logic ov;
  } flags_t;

endpackage

// ==== hw/rotate_skip_execution_unit.sv ====
// Operation
// [RULE_01] interrupt return reloads pc, sets irq enable
// [RULE_02] rotate left memory, bit7 to bit0
// [RULE_03] rotate left into accumulator, no flags
// [RULE_04] rotate left through carry, memory write
// [RULE_05] rotate left through carry into accumulator
// [RULE_06] rotate right memory, bit0 to bit7
// [RULE_07] rotate right into accumulator, no flags
// [RULE_08] rotate right through carry, memory write
// [RULE_09] rotate right through carry into accumulator
// [RULE_10] acc plus inverted mem plus carry, to acc
// [RULE_11] same subtract, result written to memory
// [RULE_12] decrement memory, skip if zero
// [RULE_13] decrement into accumulator, skip if zero
// [RULE_14] increment memory, skip if zero
// [RULE_15] increment into accumulator, skip if zero
// [RULE_16] skip discards prefetch, adds dummy cycle
// [RULE_17] whole byte set writes all ones
// [RULE_18] bit set forces one selected bit
// [RULE_19] bit test skips when bit nonzero
// [RULE_20] increment and decrement wrap modulo 256
`timescale 1ns/10ps
`default_nettype none

module rotate_skip_execution_unit #(
  parameter int DATA_W = 8,
  parameter int PC_W = 11
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic global_irq_enable,
  output logic skip_pulse
);

  // =========================================================
  // bus address phase capture
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  wire take = hsel & hready & (htrans == exec_unit_pkg::HTRANS_NONSEQ);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      rd_pend <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // =========================================================
  // architectural state
  exec_unit_pkg::op_t op;
  logic [2:0] bit_sel;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] accum;
  logic [DATA_W-1:0] result;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] stack_top;
  exec_unit_pkg::flags_t flags;
  logic busy;
  logic dummy;
  logic mem_written;
  logic skipped;
  logic done;

  wire wr_ctrl = wr_pend & (addr_q == exec_unit_pkg::ADDR_CTRL);
  wire wr_operand = wr_pend & (addr_q == exec_unit_pkg::ADDR_OPERAND);
  wire wr_accum = wr_pend & (addr_q == exec_unit_pkg::ADDR_ACCUM);
  wire wr_flags = wr_pend & (addr_q == exec_unit_pkg::ADDR_FLAGS);
  wire wr_stack = wr_pend & (addr_q == exec_unit_pkg::ADDR_STACK_TOP);
  wire go = wr_ctrl & hwdata[exec_unit_pkg::CTRL_GO_BIT] & ~busy;

  // =========================================================
  // datapath
  logic [DATA_W-1:0] m;
  assign m = operand;
  wire cin = flags.c;

  // [RULE_02] [RULE_03] plain left rotate
  wire [DATA_W-1:0] rot_l = {m[DATA_W-2:0], m[DATA_W-1]};
  // [RULE_06] [RULE_07] plain right rotate
  wire [DATA_W-1:0] rot_r = {m[0], m[DATA_W-1:1]};
  // [RULE_04] [RULE_05] nine-bit left rotate through carry
  wire [DATA_W-1:0] rot_lc = {m[DATA_W-2:0], cin};
  // [RULE_08] [RULE_09] nine-bit right rotate through carry
  wire [DATA_W-1:0] rot_rc = {cin, m[DATA_W-1:1]};

  // [RULE_10] [RULE_11] acc + ~m + c with flag taps
  wire [DATA_W:0] sbc_sum = {1'b0, accum} + {1'b0, ~m} + {{DATA_W{1'b0}}, cin};
  wire [4:0] sbc_low = {1'b0, accum[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin};
  wire [DATA_W-1:0] sbc_res = sbc_sum[DATA_W-1:0];
  wire sbc_c = sbc_sum[DATA_W];
  wire sbc_ac = sbc_low[4];
  wire sbc_z = (sbc_res == {DATA_W{1'b0}});
  wire sbc_ov = (accum[DATA_W-1] == ~m[DATA_W-1]) & (sbc_res[DATA_W-1] != accum[DATA_W-1]);

  // [RULE_20] truncated sums wrap modulo 256
  wire [DATA_W-1:0] dec_res = m - exec_unit_pkg::BYTE_ONE;
  wire [DATA_W-1:0] inc_res = m + exec_unit_pkg::BYTE_ONE;
  wire dec_zero = (dec_res == exec_unit_pkg::BYTE_ZERO);
  wire inc_zero = (inc_res == exec_unit_pkg::BYTE_ZERO);

  wire [2:0] bsel_new = hwdata[exec_unit_pkg::CTRL_BIT_LSB +: 3];
  // [RULE_18] one-hot mask of the selected bit
  wire [DATA_W-1:0] bit_mask = exec_unit_pkg::BYTE_ONE << bit_sel;
  wire bit_nz = |(m & bit_mask);

  // =========================================================
  // per-opcode outcome
  logic [DATA_W-1:0] next_result;
  logic next_mem_wr;
  logic next_acc_wr;
  logic next_skip;
  exec_unit_pkg::flags_t next_flags;
  logic next_interrupt_return_op;

  always_comb begin
    next_result = m;
    next_mem_wr = 1'b0;
    next_acc_wr = 1'b0;
    next_skip = 1'b0;
    next_flags = flags;
    next_interrupt_return_op = 1'b0;
    case (op)
      // [RULE_01] return, no flag change
      exec_unit_pkg::OP_INTERRUPT_RETURN: begin
        next_interrupt_return_op = 1'b1;
      end
      // [RULE_02] rotate left in memory
      exec_unit_pkg::OP_ROTATE_LEFT_MEM: begin
        next_result = rot_l;
        next_mem_wr = 1'b1;
      end
      // [RULE_03] rotate left to accumulator
      exec_unit_pkg::OP_ROTATE_LEFT_TO_ACCUM: begin
        next_result = rot_l;
        next_acc_wr = 1'b1;
      end
      // [RULE_04] carry takes old bit 7
      exec_unit_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
        next_result = rot_lc;
        next_mem_wr = 1'b1;
        next_flags.c = m[DATA_W-1];
      end
      // [RULE_05] carry takes old bit 7
      exec_unit_pkg::OP_ROTATE_LEFT_CARRY_TO_ACCUM: begin
        next_result = rot_lc;
        next_acc_wr = 1'b1;
        next_flags.c = m[DATA_W-1];
      end
      // [RULE_06] rotate right in memory
      exec_unit_pkg::OP_ROTATE_RIGHT_MEM: begin
        next_result = rot_r;
        next_mem_wr = 1'b1;
      end
      // [RULE_07] rotate right to accumulator
      exec_unit_pkg::OP_ROTATE_RIGHT_TO_ACCUM: begin
        next_result = rot_r;
        next_acc_wr = 1'b1;
      end
      // [RULE_08] carry takes old bit 0
      exec_unit_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        next_result = rot_rc;
        next_mem_wr = 1'b1;
        next_flags.c = m[0];
      end
      // [RULE_09] carry takes old bit 0
      exec_unit_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACCUM: begin
        next_result = rot_rc;
        next_acc_wr = 1'b1;
        next_flags.c = m[0];
      end
      // [RULE_10] subtract with borrow to accumulator
      exec_unit_pkg::OP_SUBTRACT_BORROW_TO_ACCUM: begin
        next_result = sbc_res;
        next_acc_wr = 1'b1;
        next_flags = '{c: sbc_c, ac: sbc_ac, z: sbc_z, ov: sbc_ov};
      end
      // [RULE_11] subtract with borrow to memory
      exec_unit_pkg::OP_SUBTRACT_BORROW_TO_MEM: begin
        next_result = sbc_res;
        next_mem_wr = 1'b1;
        next_flags = '{c: sbc_c, ac: sbc_ac, z: sbc_z, ov: sbc_ov};
      end
      // [RULE_12] decrement memory, skip on zero
      exec_unit_pkg::OP_DEC_SKIP_ZERO: begin
        next_result = dec_res;
        next_mem_wr = 1'b1;
        next_skip = dec_zero;
      end
      // [RULE_13] decrement to accumulator, skip on zero
      exec_unit_pkg::OP_DEC_TO_ACCUM_SKIP_ZERO: begin
        next_result = dec_res;
        next_acc_wr = 1'b1;
        next_skip = dec_zero;
      end
      // [RULE_14] increment memory, skip on zero
      exec_unit_pkg::OP_INC_SKIP_ZERO: begin
        next_result = inc_res;
        next_mem_wr = 1'b1;
        next_skip = inc_zero;
      end
      // [RULE_15] increment to accumulator, skip on zero
      exec_unit_pkg::OP_INC_TO_ACCUM_SKIP_ZERO: begin
        next_result = inc_res;
        next_acc_wr = 1'b1;
        next_skip = inc_zero;
      end
      // [RULE_17] all ones to memory
      exec_unit_pkg::OP_SET_BYTE: begin
        next_result = exec_unit_pkg::BYTE_ONES;
        next_mem_wr = 1'b1;
      end
      // [RULE_18] or in the selected bit
      exec_unit_pkg::OP_SET_BIT: begin
        next_result = m | bit_mask;
        next_mem_wr = 1'b1;
      end
      // [RULE_19] skip on selected bit set
      exec_unit_pkg::OP_BIT_TEST_SKIP_NONZERO: begin
        next_skip = bit_nz;
      end
      default: begin
        next_result = m;
      end
    endcase
  end

  // =========================================================
  // execute sequencing: one cycle, or two when skipping
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op <= exec_unit_pkg::OP_NONE;
      bit_sel <= 3'h0;
      busy <= 1'b0;
      dummy <= 1'b0;
      done <= 1'b0;
    end else begin
      if (go) begin
        op <= exec_unit_pkg::op_t'(hwdata[exec_unit_pkg::CTRL_OP_LSB +: 5]);
        bit_sel <= bsel_new;
        busy <= 1'b1;
        done <= 1'b0;
      end else if (busy && !dummy) begin
        // [RULE_16] skip adds one dummy cycle
        dummy <= next_skip;
        busy <= next_skip;
        done <= ~next_skip;
      end else if (dummy) begin
        dummy <= 1'b0;
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end

  wire exec = busy & ~dummy;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      operand <= exec_unit_pkg::BYTE_ZERO;
      result <= exec_unit_pkg::BYTE_ZERO;
      mem_written <= 1'b0;
      skipped <= 1'b0;
      skip_pulse <= 1'b0;
    end else begin
      skip_pulse <= exec & next_skip;
      if (exec) begin
        result <= next_result;
        mem_written <= next_mem_wr;
        // [RULE_16] prefetched instruction discarded
        skipped <= next_skip;
      end
      if (exec && next_mem_wr) begin
        operand <= next_result;
      end else if (wr_operand && !busy) begin
        operand <= hwdata[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accum <= exec_unit_pkg::BYTE_ZERO;
      flags <= '0;
    end else begin
      if (exec && next_acc_wr) begin
        accum <= next_result;
      end else if (wr_accum && !busy) begin
        accum <= hwdata[DATA_W-1:0];
      end
      if (exec) begin
        flags <= next_flags;
      end else if (wr_flags && !busy) begin
        flags.c <= hwdata[exec_unit_pkg::FLAG_C];
        flags.ac <= hwdata[exec_unit_pkg::FLAG_AC];
        flags.z <= hwdata[exec_unit_pkg::FLAG_Z];
        flags.ov <= hwdata[exec_unit_pkg::FLAG_OV];
      end
    end
  end

  // =========================================================
  // program counter and interrupt enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= exec_unit_pkg::PC_RESET;
      stack_top <= exec_unit_pkg::PC_RESET;
      global_irq_enable <= 1'b0;
    end else begin
      if (wr_stack && !busy) begin
        stack_top <= hwdata[PC_W-1:0];
      end
      if (exec && next_interrupt_return_op) begin
        // [RULE_01] pc from stack, enable set
        pc <= stack_top;
        global_irq_enable <= 1'b1;
      end else if (wr_flags && !busy) begin
        global_irq_enable <= hwdata[exec_unit_pkg::FLAG_GIE];
      end
    end
  end

  // =========================================================
  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      exec_unit_pkg::ADDR_CTRL: rd_mux = {27'h000_0000, op};
      exec_unit_pkg::ADDR_OPERAND: rd_mux = {24'h00_0000, operand};
      exec_unit_pkg::ADDR_ACCUM: rd_mux = {24'h00_0000, accum};
      exec_unit_pkg::ADDR_FLAGS:
        rd_mux = {27'h000_0000, global_irq_enable, flags.ov, flags.z, flags.ac, flags.c};
      exec_unit_pkg::ADDR_RESULT: rd_mux = {24'h00_0000, result};
      exec_unit_pkg::ADDR_STATUS:
        rd_mux = {28'h000_0000, mem_written, skipped, done, busy};
      exec_unit_pkg::ADDR_PC: rd_mux = {21'h00_0000, pc};
      exec_unit_pkg::ADDR_STACK_TOP: rd_mux = {21'h00_0000, stack_top};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= rd_mux;
    end
  end

  // read answers one cycle late: insert one wait state per read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= ~(take & ~hwrite);
      hresp <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== tb/exec_unit_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module exec_unit_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic global_irq_enable,
  input wire logic skip_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wc, wf;
  wire logic take = hsel && hready && htrans == exec_unit_pkg::HTRANS_NONSEQ;
  wire logic go = wc && hwdata[exec_unit_pkg::CTRL_GO_BIT];
  wire logic [4:0] opc = hwdata[4:0];
  wire logic noskip_go = go && !(opc inside {exec_unit_pkg::OP_DEC_SKIP_ZERO,
    exec_unit_pkg::OP_DEC_TO_ACCUM_SKIP_ZERO, exec_unit_pkg::OP_INC_SKIP_ZERO,
    exec_unit_pkg::OP_INC_TO_ACCUM_SKIP_ZERO, exec_unit_pkg::OP_BIT_TEST_SKIP_NONZERO});
  wire logic interrupt_return_op_go = go && opc == exec_unit_pkg::OP_INTERRUPT_RETURN;
  wire logic gie_wr = wf && hwdata[exec_unit_pkg::FLAG_GIE];
  // data-phase markers for writes to the control and flag words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wc <= 1'b0;
      wf <= 1'b0;
    end else begin
      wc <= take && hwrite && haddr == exec_unit_pkg::ADDR_CTRL;
      wf <= take && hwrite && haddr == exec_unit_pkg::ADDR_FLAGS;
    end
  end
  resp_okay_a:
    assert property (hresp == 1'b0) else $error("error response seen");
  rd_wait_a:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  wr_nowait_a:
    assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  skip_single_a:
    assert property (skip_pulse |=> !skip_pulse) else $error("skip longer than one cycle");
  skip_cause_a:
    assert property (skip_pulse |-> $past(go, 2)) else $error("skip without an op");
  noskip_ops_a:
    assert property (noskip_go |-> ##2 !skip_pulse) else $error("skip from non-skip op");
  interrupt_return_op_irq_a:
    assert property (interrupt_return_op_go |-> ##2 global_irq_enable) else $error("return left irq off");
  irq_rise_a:
    assert property ($rose(global_irq_enable) |-> $past(interrupt_return_op_go, 2) || $past(gie_wr))
    else $error("irq enable rose with no cause");
  cover property (interrupt_return_op_go);
  cover property (skip_pulse);
  cover property (take && !hwrite);
endmodule
bind rotate_skip_execution_unit exec_unit_props u_props (.mclk(mclk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .global_irq_enable(global_irq_enable), .skip_pulse(skip_pulse));
`default_nettype wire

// ==== tb/rotate_skip_execution_unit_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module rotate_skip_execution_unit_tb;
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, global_irq_enable, skip_pulse;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  int num_errors, n_tests, cyc;
  rotate_skip_execution_unit uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .global_irq_enable(global_irq_enable), .skip_pulse(skip_pulse));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================
  // checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  // ==========================================
  // bus master
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= exec_unit_pkg::HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m,
                     input logic [7:0] a, input logic [4:0] f);
    bus(1'b1, exec_unit_pkg::ADDR_OPERAND, {24'h00_0000, m});
    bus(1'b1, exec_unit_pkg::ADDR_ACCUM, {24'h00_0000, a});
    bus(1'b1, exec_unit_pkg::ADDR_FLAGS, {27'h000_0000, f});
    bus(1'b1, exec_unit_pkg::ADDR_CTRL, {15'h0000, 1'b1, 5'h00, b, 3'h0, op});
    do bus(1'b0, exec_unit_pkg::ADDR_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
  endtask
  task automatic expect_state(input logic [7:0] m, input logic [7:0] a, input logic [4:0] f);
    bus(1'b0, exec_unit_pkg::ADDR_OPERAND, 32'h0000_0000);
    check(rd, {24'h00_0000, m});
    bus(1'b0, exec_unit_pkg::ADDR_ACCUM, 32'h0000_0000);
    check(rd, {24'h00_0000, a});
    bus(1'b0, exec_unit_pkg::ADDR_FLAGS, 32'h0000_0000);
    check(rd, {27'h000_0000, f});
  endtask
  // ==========================================
  // scenarios
  task automatic t_rotate();
    logic [4:0] op [9] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h08};
    logic [7:0] m [9] = '{8'h97, 8'h97, 8'h97, 8'h97, 8'h97, 8'h97, 8'h97, 8'h97, 8'h96};
    logic [4:0] f [9] = '{5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h01};
    logic [7:0] em [9] = '{8'h2F, 8'h97, 8'h2E, 8'h97, 8'hCB, 8'h97, 8'h4B, 8'h97, 8'hCB};
    logic [7:0] ea [9] = '{8'h3C, 8'h2F, 8'h3C, 8'h2E, 8'h3C, 8'hCB, 8'h3C, 8'h4B, 8'h3C};
    logic [4:0] ef [9] = '{5'h0E, 5'h0E, 5'h0F, 5'h0F, 5'h0E, 5'h0E, 5'h0F, 5'h0F, 5'h00};
    for (int i = 0; i < 9; i++) begin
      run(op[i], 3'h0, m[i], 8'h3C, f[i]);
      expect_state(em[i], ea[i],
                   ef[i]);
    end
  endtask
  task automatic t_sbc();
    logic [4:0] op [4] = '{5'h0A, 5'h0B, 5'h0A, 5'h0B};
    logic [7:0] m [4] = '{8'h20, 8'h01, 8'h10, 8'h10};
    logic [7:0] a [4] = '{8'h50, 8'h80, 8'h10, 8'h10};
    logic [4:0] f [4] = '{5'h01, 5'h00, 5'h01, 5'h01};
    logic [7:0] em [4] = '{8'h20, 8'h7E, 8'h10, 8'h00};
    logic [7:0] ea [4] = '{8'h30, 8'h80, 8'h00, 8'h10};
    logic [4:0] ef [4] = '{5'h03, 5'h09, 5'h07, 5'h07};
    for (int i = 0; i < 4; i++) begin
      run(op[i], 3'h0, m[i], a[i], f[i]);
      expect_state(em[i], ea[i], ef[i]);
    end
  endtask
  task automatic t_skip_set();
    logic [4:0] op [12] = '{5'h0C, 5'h0C, 5'h0D, 5'h0E, 5'h0E, 5'h0F, 5'h0F, 5'h12, 5'h12,
                            5'h10, 5'h11, 5'h11};
    logic [2:0] b [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h0, 3'h5,
                           3'h0};
    logic [7:0] m [12] = '{8'h01, 8'h00, 8'h01, 8'hFF, 8'h7F, 8'hFF, 8'h00, 8'h08, 8'hF7,
                           8'h12, 8'h00, 8'h10};
    logic [7:0] em [12] = '{8'h00, 8'hFF, 8'h01, 8'h00, 8'h80, 8'hFF, 8'h00, 8'h08, 8'hF7,
                            8'hFF, 8'h20, 8'h11};
    logic [7:0] ea [12] = '{8'h55, 8'h55, 8'h00, 8'h55, 8'h55, 8'h00, 8'h01, 8'h55, 8'h55,
                            8'h55, 8'h55, 8'h55};
    logic sk [12] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 12; i++) begin
      run(op[i], b[i], m[i], 8'h55, 5'h0F);
      check({30'h0, rd[2:1]}, {30'h0, sk[i], 1'b1});
      expect_state(em[i], ea[i],
                   5'h0F);
    end
  endtask
  task automatic t_interrupt_return_op();
    bus(1'b1, exec_unit_pkg::ADDR_STACK_TOP, 32'h0000_05A3);
    run(5'h01, 3'h0, 8'h66, 8'h77, 5'h0B);
    bus(1'b0, exec_unit_pkg::ADDR_PC, 32'h0000_0000);
    check(rd, 32'h0000_05A3);
    check({31'h0000_0000, global_irq_enable}, 32'h0000_0001);
    expect_state(8'h66, 8'h77, 5'h1B);
    bus(1'b1, exec_unit_pkg::ADDR_FLAGS, 32'h0000_0000);
    // the flag word lands on the edge the bus task returns at
    @(posedge mclk);
    check({31'h0000_0000, global_irq_enable}, 32'h0000_0000);
    bus(1'b1, 8'h40, 32'h0000_1234);
    bus(1'b0, 8'h40, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_rotate();
    t_sbc();
    t_skip_set();
    t_interrupt_return_op();
    stop_test();
  end
endmodule
`default_nettype wire
